// file: core/sfh_consts.svh
`ifndef SFH_CONSTS_SVH
`define SFH_CONSTS_SVH

// System clock and serial clock timing
`define SFH_CLK_NS          25
`define SFH_SCK_PERIOD_NS   400
`define SFH_SCK_HALF_CYC    (((`SFH_SCK_PERIOD_NS / 2) + `SFH_CLK_NS - 1) / `SFH_CLK_NS)

// Address field positions
`define SFH_ADDR_MSB        23
`define SFH_SECTOR_LSB      12
`define SFH_BLK32_LSB       15
`define SFH_BLK64_LSB       16
`define SFH_ADDR_BITS_DEF   19

// Line enables and bits per rising edge
`define SFH_IO_RELEASE      4'hF
`define SFH_IO_SINGLE_OE_N  4'hD
`define SFH_BITS_SINGLE     3'h1
`define SFH_BITS_QUAD       3'h4

`endif

// file: core/sfh_device.sv
// Overview of operation
// - Pause freezes transfer, resumes from same point
// - Pause is active low, only while selected
// - Paused and selected: output lines released
// - Pause input high resumes the transfer
// - Quad enable turns pause pin into data_line_3
// - Only serial clock modes 0 and 3
// - Master parks clock low mode 0, high mode 3
// - Capture on rising edge, launch on falling
// - Multi-line: data_line_0..3 on the four pins
// - Master holds unused pins at defined levels
// - Small densities: 4K sectors, 32K blocks
// - Larger densities: 4K sectors, 32/64K blocks
// - Optional variant has no 64K blocks
// - Status bits govern array write protection
// - Deselected: outputs released, input ignored
`timescale 1ns/1ps
`default_nettype none
`include "sfh_consts.svh"

module sfh_device #(
    parameter int ADDR_BITS = `SFH_ADDR_BITS_DEF,
    parameter bit HAS_BLK64 = 1'b1
) (
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_rst_n,
    sfh_link_if.device                   bus,
    input  wire logic                    i_quad_enable_bit,
    input  wire logic                    i_quad_xfer,
    input  wire logic                    i_quad_out,
    input  wire logic [7:0]              i_tx_byte,
    input  wire logic [23:0]             i_addr,
    input  wire logic [2:0]              i_protect_level,
    output logic      [7:0]              o_rx_byte,
    output logic                         o_rx_valid,
    output logic                         o_tx_taken,
    output logic                         o_selected,
    output logic                         o_paused,
    output logic      [11:0]             o_sector,
    output logic      [8:0]              o_blk32,
    output logic      [7:0]              o_blk64,
    output logic                         o_blk64_valid,
    output logic                         o_in_range,
    output logic                         o_protected
);
    import sfh_pkg::*;

    sfh_dev_regs_t r;
    sfh_dev_regs_t n;

    logic       sck;
    logic       cs_n;
    logic [3:0] io;
    logic       rise;
    logic       fall;
    logic       paused;
    logic       quad;
    logic [2:0] step;
    logic [2:0] cnt_n;
    logic [7:0] sin;
    logic [7:0] src;
    logic [9:0] n32;
    logic [9:0] prot_cnt;
    logic [9:0] blk32_w;

    // Only the second synchroniser stage is read
    assign sck  = r.sync2[5];
    assign cs_n = r.sync2[4];
    assign io   = r.sync2[3:0];
    assign rise = sck & ~r.sck_prev;
    assign fall = ~sck & r.sck_prev;
    assign paused = ~io[3] & ~i_quad_enable_bit;
    assign quad = i_quad_enable_bit & i_quad_xfer;
    assign step = quad ? `SFH_BITS_QUAD : `SFH_BITS_SINGLE;
    assign cnt_n = r.bit_cnt + step;
    assign sin = quad ? {r.shift_in[3:0], io} : {r.shift_in[6:0], io[0]};
    assign src = (r.bit_cnt == 3'h0) ? i_tx_byte : r.shift_out;

    // Top protected region in 32K blocks, counted from the top of the array
    assign n32      = 10'(1) << (ADDR_BITS - `SFH_BLK32_LSB);
    assign blk32_w  = {1'b0, i_addr[`SFH_ADDR_MSB:`SFH_BLK32_LSB]};
    assign prot_cnt = (i_protect_level == 3'h0) ? 10'h000 : (10'(1) << (i_protect_level - 3'h1));

    always_comb
    begin
        n          = r;
        n.rx_valid = 1'b0;
        n.tx_taken = 1'b0;
        n.sync1    = {bus.sck, bus.cs_n, bus.io};
        n.sync2    = r.sync1;
        n.sck_prev = sck;
        case (r.state)
            SFH_DEV_IDLE:
            begin
                n.bit_cnt = 3'h0;
                if (!cs_n)
                begin
                    n.state = paused ? SFH_DEV_PAUSED : SFH_DEV_ACTIVE;
                end
            end
            SFH_DEV_ACTIVE:
            begin
                if (cs_n)
                begin
                    n.state = SFH_DEV_IDLE;
                end
                else if (paused)
                begin
                    n.state = SFH_DEV_PAUSED;
                end
                else
                begin
                    if (rise)
                    begin
                        n.shift_in = sin;
                        n.bit_cnt  = cnt_n;
                        if (cnt_n == 3'h0)
                        begin
                            n.rx_byte  = sin;
                            n.rx_valid = 1'b1;
                        end
                    end
                    if (fall)
                    begin
                        n.tx_taken = (r.bit_cnt == 3'h0);
                        if (quad)
                        begin
                            n.io_o      = src[7:4];
                            n.shift_out = {src[3:0], 4'h0};
                        end
                        else
                        begin
                            n.io_o      = {2'b00, src[7], 1'b0};
                            n.shift_out = {src[6:0], 1'b0};
                        end
                    end
                end
            end
            SFH_DEV_PAUSED:
            begin
                if (cs_n)
                begin
                    n.state = SFH_DEV_IDLE;
                end
                else if (!paused)
                begin
                    n.state = SFH_DEV_ACTIVE;
                end
            end
            default:
            begin
                n.state = SFH_DEV_IDLE;
            end
        endcase
        if (n.state != SFH_DEV_ACTIVE)
        begin
            n.io_oe_n = `SFH_IO_RELEASE;
        end
        else if (quad)
        begin
            n.io_oe_n = i_quad_out ? 4'h0 : `SFH_IO_RELEASE;
        end
        else
        begin
            n.io_oe_n = `SFH_IO_SINGLE_OE_N;
        end
        n.addr     = i_addr;
        n.in_range = ((i_addr >> ADDR_BITS) == 24'h000000);
        n.protect  = (blk32_w < n32) && ((blk32_w + prot_cnt) >= n32);
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            r <= '{sync1: 6'h3F, sync2: 6'h3F, sck_prev: 1'b0, state: SFH_DEV_IDLE,
                   bit_cnt: 3'h0, shift_in: 8'h00, shift_out: 8'h00, rx_byte: 8'h00,
                   rx_valid: 1'b0, tx_taken: 1'b0, io_o: 4'h0, io_oe_n: `SFH_IO_RELEASE,
                   addr: 24'h000000, in_range: 1'b0, protect: 1'b0};
        end
        else
        begin
            r <= n;
        end
    end

    assign bus.dev_io_o    = r.io_o;
    assign bus.dev_io_oe_n = r.io_oe_n;
    assign o_rx_byte       = r.rx_byte;
    assign o_rx_valid      = r.rx_valid;
    assign o_tx_taken      = r.tx_taken;
    assign o_selected      = (r.state != SFH_DEV_IDLE);
    assign o_paused        = (r.state == SFH_DEV_PAUSED);
    assign o_sector        = r.addr[`SFH_ADDR_MSB:`SFH_SECTOR_LSB];
    assign o_blk32         = r.addr[`SFH_ADDR_MSB:`SFH_BLK32_LSB];
    assign o_blk64         = r.addr[`SFH_ADDR_MSB:`SFH_BLK64_LSB];
    assign o_blk64_valid   = HAS_BLK64 && (ADDR_BITS > `SFH_BLK64_LSB);
    assign o_in_range      = r.in_range;
    assign o_protected     = r.protect;

endmodule

`default_nettype wire

// file: core/sfh_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfh_consts.svh"

module sfh_host #(
    parameter bit CPOL     = 1'b0,
    parameter int HALF_CYC = `SFH_SCK_HALF_CYC
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_n,
    sfh_link_if.host        bus,
    input  wire logic       i_select,
    input  wire logic       i_start,
    input  wire logic [7:0] i_tx_byte,
    input  wire logic       i_quad_xfer,
    input  wire logic       i_quad_read,
    input  wire logic       i_hold_req,
    input  wire logic       i_wp_level,
    output logic            o_busy,
    output logic            o_done,
    output logic      [7:0] o_rx_byte
);
    import sfh_pkg::*;

    sfh_host_regs_t r;
    sfh_host_regs_t n;

    logic       tick;
    logic [3:0] nbits;
    logic [3:0] idle_oe_n;
    logic [3:0] idle_o;

    assign tick  = (r.div == 8'(HALF_CYC - 1));
    assign nbits = i_quad_xfer ? 4'h2 : 4'h8;
    // Unused lines sit at defined levels: write protect and pause
    assign idle_o    = {~i_hold_req, i_wp_level, 1'b0, 1'b0};
    assign idle_oe_n = i_quad_xfer ? (i_quad_read ? `SFH_IO_RELEASE : 4'h0) : 4'h2;

    always_comb
    begin
        n       = r;
        n.done  = 1'b0;
        n.sync1 = bus.io;
        n.sync2 = r.sync1;
        n.cs_n  = ~i_select;
        case (r.state)
            SFH_HOST_IDLE:
            begin
                n.sck     = CPOL;
                n.div     = 8'h00;
                n.io_oe_n = idle_oe_n;
                n.io_o    = i_quad_xfer ? r.io_o : {idle_o[3:1], r.io_o[0]};
                if (i_start && i_select && !r.cs_n)
                begin
                    n.state = SFH_HOST_SHIFT;
                    n.edges = 5'h00;
                    n.rises = 4'h0;
                    if (i_quad_xfer)
                    begin
                        n.io_o = i_tx_byte[7:4];
                        n.tx   = {i_tx_byte[3:0], 4'h0};
                    end
                    else
                    begin
                        n.io_o = {idle_o[3:1], i_tx_byte[7]};
                        n.tx   = {i_tx_byte[6:0], 1'b0};
                    end
                end
            end
            SFH_HOST_SHIFT:
            begin
                n.io_oe_n = idle_oe_n;
                if (!i_quad_xfer)
                begin
                    n.io_o[3:1] = idle_o[3:1];
                end
                // Pausing stops the clock mid-byte; the byte resumes afterwards
                // The clock restarts one cycle after the pause line rises, so no edge meets the resume
                if (i_quad_xfer || (!i_hold_req && r.io_o[3]))
                begin
                    n.div = tick ? 8'h00 : r.div + 8'h01;
                    if (tick)
                    begin
                        n.sck   = ~r.sck;
                        n.edges = r.edges + 5'h01;
                        if (!r.sck)
                        begin
                            n.rx    = i_quad_xfer ? {r.rx[3:0], r.sync2} : {r.rx[6:0], r.sync2[1]};
                            n.rises = r.rises + 4'h1;
                        end
                        else if (r.rises != 4'h0 && r.rises < nbits)
                        begin
                            if (i_quad_xfer)
                            begin
                                n.io_o = r.tx[7:4];
                                n.tx   = {r.tx[3:0], 4'h0};
                            end
                            else
                            begin
                                n.io_o[0] = r.tx[7];
                                n.tx      = {r.tx[6:0], 1'b0};
                            end
                        end
                        if (n.edges == {nbits, 1'b0})
                        begin
                            n.state   = SFH_HOST_IDLE;
                            n.done    = 1'b1;
                            n.rx_byte = n.rx;
                        end
                    end
                end
            end
            default:
            begin
                n.state = SFH_HOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            r <= '{sync1: 4'hF, sync2: 4'hF, state: SFH_HOST_IDLE, div: 8'h00, sck: CPOL,
                   cs_n: 1'b1, edges: 5'h00, rises: 4'h0, tx: 8'h00, rx: 8'h00,
                   rx_byte: 8'h00, done: 1'b0, io_o: 4'hC, io_oe_n: `SFH_IO_RELEASE};
        end
        else
        begin
            r <= n;
        end
    end

    assign bus.sck          = r.sck;
    assign bus.cs_n         = r.cs_n;
    assign bus.host_io_o    = r.io_o;
    assign bus.host_io_oe_n = r.io_oe_n;
    assign o_busy           = (r.state == SFH_HOST_SHIFT);
    assign o_done           = r.done;
    assign o_rx_byte        = r.rx_byte;

endmodule

`default_nettype wire

// file: core/sfh_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sfh_link_if;
    logic       sck;
    logic       cs_n;
    logic [3:0] host_io_o;
    logic [3:0] host_io_oe_n;
    logic [3:0] dev_io_o;
    logic [3:0] dev_io_oe_n;
    logic [3:0] io;

    // Wire level of each data line; an undriven line is pulled high
    assign io = (~dev_io_oe_n & dev_io_o)
              | (dev_io_oe_n & ~host_io_oe_n & host_io_o)
              | (dev_io_oe_n & host_io_oe_n);

    modport device (
        input  sck,
        input  cs_n,
        input  io,
        output dev_io_o,
        output dev_io_oe_n
    );

    modport host (
        output sck,
        output cs_n,
        output host_io_o,
        output host_io_oe_n,
        input  io
    );
endinterface

`default_nettype wire

// file: core/sfh_pkg.sv
package sfh_pkg;

    typedef enum logic [1:0] {SFH_DEV_IDLE, SFH_DEV_ACTIVE, SFH_DEV_PAUSED} sfh_dev_state_t;

    typedef enum logic {SFH_HOST_IDLE, SFH_HOST_SHIFT} sfh_host_state_t;

    typedef struct packed {
        logic [5:0]     sync1;
        logic [5:0]     sync2;
        logic           sck_prev;
        sfh_dev_state_t state;
        logic [2:0]     bit_cnt;
        logic [7:0]     shift_in;
        logic [7:0]     shift_out;
        logic [7:0]     rx_byte;
        logic           rx_valid;
        logic           tx_taken;
        logic [3:0]     io_o;
        logic [3:0]     io_oe_n;
        logic [23:0]    addr;
        logic           in_range;
        logic           protect;
    } sfh_dev_regs_t;

    typedef struct packed {
        logic [3:0]      sync1;
        logic [3:0]      sync2;
        sfh_host_state_t state;
        logic [7:0]      div;
        logic            sck;
        logic            cs_n;
        logic [4:0]      edges;
        logic [3:0]      rises;
        logic [7:0]      tx;
        logic [7:0]      rx;
        logic [7:0]      rx_byte;
        logic            done;
        logic [3:0]      io_o;
        logic [3:0]      io_oe_n;
    } sfh_host_regs_t;

endpackage

// file: testbench/serial_flash_hold_and_sector_map_test.sv
`timescale 1ns/1ps
`default_nettype none

module serial_flash_hold_and_sector_map_test;
    logic        clk, rst_n, sel, start, qx, qr, hold, wp, qe, ok;
    logic        done, paused, sltd, b64v, b64v2, inr, inr2, prd, pq, rxv, txt, busy;
    logic [7:0]  htx, dtx, hrx, drx, drx2, want, b, blk64;
    logic [23:0] addr, a;
    logic [2:0]  prot;
    logic [11:0] sector;
    logic [8:0]  blk32;
    int          mismatches, n_checks, k;
    int          cyc = 0;
    int          nrx = 0;
    int          ntx = 0;
    int          kinds [7] = '{0, 1, 2, 3, 3, 2, 1};
    logic [23:0] corners [4] = '{24'h008000, 24'h00FFFF, 24'h010000, 24'h07FFFF};

    sfh_link_if lnk();
    sfh_link_if lnk2();
    sfh_host i_sfh_host (.i_clk_sys(clk), .i_rst_n(rst_n), .bus(lnk), .i_select(sel), .i_start(start),
        .i_tx_byte(htx), .i_quad_xfer(qx), .i_quad_read(qr), .i_hold_req(hold), .i_wp_level(wp),
        .o_busy(busy), .o_done(done), .o_rx_byte(hrx));
    sfh_device i_sfh_device (.i_clk_sys(clk), .i_rst_n(rst_n), .bus(lnk), .i_quad_enable_bit(qe),
        .i_quad_xfer(qx), .i_quad_out(qr), .i_tx_byte(dtx), .i_addr(addr), .i_protect_level(prot),
        .o_rx_byte(drx), .o_rx_valid(rxv), .o_tx_taken(txt), .o_selected(sltd), .o_paused(paused),
        .o_sector(sector), .o_blk32(blk32), .o_blk64(blk64), .o_blk64_valid(b64v), .o_in_range(inr),
        .o_protected(prd));
    sfh_device #(.ADDR_BITS(16), .HAS_BLK64(1'b0)) i_sfh_device_b (.i_clk_sys(clk), .i_rst_n(rst_n),
        .bus(lnk2), .i_quad_enable_bit(1'b0), .i_quad_xfer(qx), .i_quad_out(qr), .i_tx_byte(dtx),
        .i_addr(addr), .i_protect_level(prot), .o_rx_byte(drx2), .o_rx_valid(), .o_tx_taken(),
        .o_selected(), .o_paused(), .o_sector(), .o_blk32(), .o_blk64(), .o_blk64_valid(b64v2),
        .o_in_range(inr2), .o_protected());
    sfh_link_assertions #(.CPOL(1'b0)) i_sfh_link_assertions (.i_clk_sys(clk), .i_rst_n(rst_n),
        .sck(lnk.sck), .cs_n(lnk.cs_n), .host_io_o(lnk.host_io_o), .host_io_oe_n(lnk.host_io_oe_n),
        .dev_io_o(lnk.dev_io_o), .dev_io_oe_n(lnk.dev_io_oe_n), .io(lnk.io));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    function automatic logic prot_exp(input logic [23:0] ad, input logic [2:0] lv);
        return lv != 3'h0 && int'(ad[23:15]) >= 16 - (1 << (lv - 1));
    endfunction

    // One byte through the host; the device answers with the byte staged one transfer earlier,
    // laid out for the line mode of that earlier transfer, so it is checked only if the mode is kept
    task automatic xfer(input logic q, input logic r, input logic h, input logic [7:0] t);
        int n;
        int rx0;
        int tx0;
        n = 0;
        @(negedge clk);
        rx0   = nrx;
        tx0   = ntx;
        qx    = q;
        qr    = r;
        qe    = q | (!h & 1'($urandom));
        htx   = t;
        wp    = 1'($urandom);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        chk(busy, 1'b1, "busy");
        if (h)
        begin
            repeat (40) @(negedge clk);
            hold = 1'b1;
            repeat (30) @(negedge clk);
            chk(paused, 1'b1, "pause");
            hold = 1'b0;
        end
        while (done !== 1'b1 && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        chk({done, busy}, 2'h2, "done");
        if (ok && pq == q && (!q || r)) chk(hrx, want, "host rx");
        if (!r) chk(drx, t, "device rx");
        if (q) chk(paused, 1'b0, "quad pause");
        repeat (6) @(negedge clk);
        chk(24'(nrx - rx0), 24'h000001, "rx pulses");
        chk(24'(ntx - tx0), 24'h000001, "tx pulses");
        want = dtx;
        dtx  = 8'($urandom);
        ok   = 1'b1;
        pq   = q;
    endtask

    // Mode 3 byte on the second link, clock made by the bench
    task automatic bang(input logic [7:0] v);
        for (int i = 7; i >= 0; i--)
        begin
            @(negedge clk);
            lnk2.sck          = 1'b0;
            lnk2.host_io_o[0] = v[i];
            repeat (4) @(negedge clk);
            lnk2.sck = 1'b1;
            repeat (3) @(negedge clk);
        end
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (rxv) nrx++;
        if (txt) ntx++;
        if (cyc == 10000)
        begin
            mismatches++;
            conclude();
        end
    end

    initial
    begin
        {rst_n, sel, start, qx, qr, hold, qe, ok, wp} = 9'h001;
        {htx, dtx, want, addr, prot} = 51'h0;
        {lnk2.sck, lnk2.cs_n, lnk2.host_io_o, lnk2.host_io_oe_n} = 10'h3C2;
        mismatches = 0;
        n_checks   = 0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        void'($urandom(32'h489C));
        for (int i = 0; i < 24; i++)
        begin
            a = (i < 4) ? corners[i] : 24'($urandom % 32'h000A0000);
            @(negedge clk);
            addr = a;
            prot = 3'($urandom);
            repeat (2) @(negedge clk);
            chk(sector, a[23:12], "sector");
            chk(blk32, a[23:15], "block 32K");
            chk(blk64, a[23:16], "block 64K");
            chk({b64v, b64v2}, 2'h2, "64K grouping");
            chk({inr, inr2}, {a < 24'h080000, a < 24'h010000}, "range");
            if (a < 24'h080000) chk(prd, prot_exp(a, prot), "protect");
        end
        $display("test decode done");
        sel = 1'b1;
        repeat (8) @(negedge clk);
        chk(sltd, 1'b1, "selected");
        for (int i = 0; i < 16; i++)
        begin
            k = (i < 7) ? kinds[i] : int'($urandom % 4);
            xfer(k > 1, k == 3, k == 1, (i == 2) ? 8'h00 : 8'($urandom));
        end
        sel = 1'b0;
        repeat (8) @(negedge clk);
        chk(sltd, 1'b0, "deselected");
        $display("test link done");
        bang(8'h5A);
        chk(lnk2.dev_io_oe_n, 4'hF, "released");
        lnk2.cs_n = 1'b0;
        repeat (6) @(negedge clk);
        b = 8'($urandom);
        bang(b);
        repeat (8) @(negedge clk);
        chk(drx2, b, "mode 3 rx");
        lnk2.cs_n = 1'b1;
        $display("test mode3 done");
        conclude();
    end
endmodule

`default_nettype wire

// file: testbench/sfh_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module sfh_link_assertions #(
    parameter bit CPOL = 1'b0
) (
    input wire logic       i_clk_sys,
    input wire logic       i_rst_n,
    input wire logic       sck,
    input wire logic       cs_n,
    input wire logic [3:0] host_io_o,
    input wire logic [3:0] host_io_oe_n,
    input wire logic [3:0] dev_io_o,
    input wire logic [3:0] dev_io_oe_n,
    input wire logic [3:0] io
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    logic       sck_d;
    logic [3:0] fall_age;

    // Cycles since the last falling serial clock edge, saturating
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sck_d    <= CPOL;
            fall_age <= 4'hF;
        end
        else
        begin
            sck_d    <= sck;
            fall_age <= (sck_d && !sck) ? 4'h0 : fall_age + {3'h0, fall_age != 4'hF};
        end
    end

    property p_idle_release;
        cs_n [*5] |-> dev_io_oe_n == 4'hF;
    endproperty
    a_idle_release: assert property (p_idle_release) else $error("lines driven while deselected");
    property p_idle_clock;
        cs_n |-> sck == CPOL;
    endproperty
    a_idle_clock: assert property (p_idle_clock) else $error("clock not parked");
    property p_pause_release;
        (host_io_oe_n == 4'h2 && !host_io_o[3] && !cs_n) [*5] |-> dev_io_oe_n[1];
    endproperty
    a_pause_release: assert property (p_pause_release) else $error("output driven in pause");
    property p_pause_freeze;
        (host_io_oe_n == 4'h2 && !host_io_o[3] && !cs_n) [*3] |-> $stable(sck);
    endproperty
    a_pause_freeze: assert property (p_pause_freeze) else $error("clock moved in pause");
    property p_resume;
        $rose(io[3]) && host_io_oe_n == 4'h2 && !cs_n |-> ##[1:6] !dev_io_oe_n[1];
    endproperty
    a_resume: assert property (p_resume) else $error("no resume");
    property p_launch;
        dev_io_oe_n == 4'hD && $past(dev_io_oe_n) == 4'hD && $changed(dev_io_o[1]) |-> fall_age < 4'h8;
    endproperty
    a_launch: assert property (p_launch) else $error("output changed away from falling edge");
    property p_capture;
        $rose(sck) && !cs_n && !host_io_oe_n[0] |-> $stable(host_io_o[0]) [*4];
    endproperty
    a_capture: assert property (p_capture) else $error("data moved at rising edge");
    property p_line_sets;
        dev_io_oe_n inside {4'hF, 4'hD, 4'h0};
    endproperty
    a_line_sets: assert property (p_line_sets) else $error("odd line enables");
    property p_pins_held;
        host_io_oe_n[3:2] != 2'b00 |-> host_io_oe_n == 4'hF;
    endproperty
    a_pins_held: assert property (p_pins_held) else $error("spare pins floating");

    c_pause: cover property (host_io_oe_n == 4'h2 && !io[3] && !cs_n);
    c_quad_read: cover property (dev_io_oe_n == 4'h0);
    c_select: cover property ($fell(cs_n));
endmodule

`default_nettype wire
